// >>> ssod_decoder.sv
// short opcode decoder: serial link slave for one-byte and two-byte
// commands, and the control bits those commands drive.
// assumes the host is a mode-0 master; sck only runs inside frames.
//
// How it works
// [R1] one-byte opcodes look like 11xxxxx0, taken MSB first on si.
// [R2] so is driven with junk the whole time chip select is low.
// [R3] one-byte commands send back nothing useful on so.
// [R4] after a one-byte command the next opcode is taken at once.
// [R5] host keeps chip select low through all eight opcode bits.
// [R6] host resends a command that may have been cut short.
// [R7] every one-byte opcode acts whatever bank is selected.
// [R8] four opcodes select bank 0 to 3, held in a state register.
// [R9] bank is 0 after reset and changes only by opcode or reset.
// [R10] banked register addresses resolve in the selected bank.
// [R11] reset opcode sets reset-request bit 4 of control word two.
// [R12] four pause opcodes write 00 to 11 into control one bits 7:6.
// [R13] count-down opcode sets packet-decrement bit 8 of control one.
// [R14] mover stop opcode clears mover start bit 5 of control one.
// [R15] four mover opcodes write bits 5:2 to 1000, 1010, 1100, 1110.
// [R16] send opcode sets transmit-request bit 1 of control one.
// [R17] receive on/off opcodes set or clear bit 0 of control one.
// [R18] irq on/off opcodes set or clear bit 15 of the status word.
// [R19] bank read: opcode C8, then bank returned MSB first in byte 2.
// [R20] after the bank read the next command is decoded at once.
// [R21] bank read changes no state; aborting it is harmless.
// [R22] mode 0: sample si on sck rise, change so on sck fall.
// [R23] so released whenever chip select is high.
// [R24] chip select low restarts decoding; high drops a partial byte.
module ssod_decoder (
    // system side
    input wire logic clk_sys,
    input wire logic rstn,
    // serial link, clocked by the host
    input wire logic sck,
    input wire logic csn,
    input wire logic si,
    output logic so,
    output logic soOen,
    // banked address resolution
    input wire logic [4:0] bankedAddr,
    output logic [6:0] resolvedAddr,
    // completion reports from the engines
    input wire logic transmitDone,
    input wire logic moverDone,
    // control state seen by the engines
    output logic [1:0] bank,
    output logic [15:0] ethernetControl1,
    output logic [15:0] ethernetControl2,
    output logic [15:0] ethernetStatus
);
    import ssod_pkg::*;

    ////////////////////////////////////////////////////////////////
    // link side: bit counting and framing

    logic frameRstn;
    logic [2:0] bitCount;
    logic [6:0] shiftIn;
    logic [7:0] fullByte;
    logic byteDone;
    logic isShortOp;
    ssod_phase_t phase;

    // chip select high or rstn low clears the frame logic
    // [R24] frame restart
    assign frameRstn = rstn & ~csn;

    // the byte as it stands on its last rising edge
    assign fullByte = {shiftIn, si};
    assign byteDone = (bitCount == LAST_BIT);

    // one-byte opcode frame, the bank read excluded
    // [R1] opcode frame check
    assign isShortOp = (fullByte[7:6] == SHORT_OP_TOP)
                       && !fullByte[0]
                       && (fullByte != OP_READ_BANK);

    // [R22] sample on rise
    always_ff @(posedge sck or negedge frameRstn) begin
        if (!frameRstn) begin
            bitCount <= FIRST_BIT;
            shiftIn <= 7'h00;
        end else begin
            bitCount <= bitCount + 3'h1; // wraps after the eighth bit
            shiftIn <= fullByte[6:0];
        end
    end

    // byte meaning: opcode, or the reply byte of a bank read
    // [R19] reply byte follows
    // [R20] decode resumes
    always_ff @(posedge sck or negedge frameRstn) begin
        if (!frameRstn) begin
            phase <= PH_OPCODE;
        end else if (byteDone) begin
            unique case (phase)
                PH_OPCODE: begin
                    if (fullByte == OP_READ_BANK) begin
                        phase <= PH_REPLY;
                    end
                end
                PH_REPLY: begin
                    phase <= PH_OPCODE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // link side: handing a command to the system clock

    logic cmdToggle;
    logic [7:0] cmdByte;

    // the byte is held until the next command, so it is stable long
    // before the system side sees the toggle change.
    // only a full eighth bit gets here, a cut byte never toggles.
    // [R4] back to back
    // [R5] full byte only
    // [R21] reply bytes never run
    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            cmdToggle <= 1'b0;
            cmdByte <= 8'h00;
        end else if (byteDone && phase == PH_OPCODE && isShortOp) begin
            cmdToggle <= ~cmdToggle;
            cmdByte <= fullByte;
        end
    end

    ////////////////////////////////////////////////////////////////
    // link side: serial output

    logic [1:0] bankLink;
    logic [7:0] soByte;

    // bank seen on the link clock; changes long before any reply
    // the two bits may skew for one sck period, settled well before the reply load
    ssod_sync #(
        .W(2)
    ) bankToLink (
        .clk(sck),
        .rstn(rstn),
        .d(bank),
        .q(bankLink)
    );

    // reply loads on the fall that opens the second byte.
    // outside a reply the register shifts out whatever it holds.
    // [R22] change on fall
    // [R19] bank reply
    // [R3] junk otherwise
    always_ff @(negedge sck or negedge frameRstn) begin
        if (!frameRstn) begin
            soByte <= 8'h00;
        end else if (phase == PH_REPLY && bitCount == FIRST_BIT) begin
            soByte <= {6'h00, bankLink};
        end else begin
            soByte <= {soByte[6:0], 1'b0};
        end
    end

    // [R2] driven while selected
    assign so = soByte[7];

    // enable is low while the pin is driven
    // [R23] release when idle
    assign soOen = csn;

    ////////////////////////////////////////////////////////////////
    // system side: command arrival

    logic cmdToggleSys;
    logic cmdToggleSeen;
    logic cmdEvent;

    ssod_sync #(
        .W(1)
    ) toggleToSys (
        .clk(clk_sys),
        .rstn(rstn),
        .d(cmdToggle),
        .q(cmdToggleSys)
    );

    // one cycle event per command
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmdToggleSeen <= 1'b0;
        end else begin
            cmdToggleSeen <= cmdToggleSys;
        end
    end

    // either toggle edge marks one new command
    assign cmdEvent = cmdToggleSys ^ cmdToggleSeen;

    ////////////////////////////////////////////////////////////////
    // system side: system reset request

    logic sysReset;

    // request lasts one cycle; the cycle after, bank and the three system-side words
    // return to their reset values; the link side keeps its state
    assign sysReset = ethernetControl2[CTRL2_RESET_REQUEST];

    // [R11] reset request
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ethernetControl2 <= CTRL2_RESET;
        end else if (sysReset) begin
            ethernetControl2 <= CTRL2_RESET;
        end else if (cmdEvent && cmdByte == OP_SYSTEM_RESET) begin
            ethernetControl2[CTRL2_RESET_REQUEST] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // system side: bank state

    // no bank-dependent gating on any one-byte opcode
    // [R7] bank independent
    // [R8] bank select
    // [R9] bank reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bank <= BANK_RESET;
        end else if (sysReset) begin
            bank <= BANK_RESET;
        end else if (cmdEvent) begin
            unique case (cmdByte)
                OP_SELECT_BANK_ZERO: bank <= 2'h0;
                OP_SELECT_BANK_ONE: bank <= 2'h1;
                OP_SELECT_BANK_TWO: bank <= 2'h2;
                OP_SELECT_BANK_THREE: bank <= 2'h3;
                default: bank <= bank;
            endcase
        end
    end

    // the register engines index with bank above the address
    // [R10] banked address
    assign resolvedAddr = {bank, bankedAddr};

    ////////////////////////////////////////////////////////////////
    // system side: first control word

    logic [15:0] next_control1;

    // engine completions first, then command effects.
    // a set in the same cycle as a done wins over the clear.
    always_comb begin
        next_control1 = ethernetControl1;
        // packet decrement is a one-cycle pulse
        next_control1[CTRL1_PACKET_DECREMENT] = 1'b0;
        if (transmitDone) begin
            next_control1[CTRL1_TRANSMIT_REQUEST] = 1'b0;
        end
        if (moverDone) begin
            next_control1[CTRL1_MOVER_START] = 1'b0;
        end
        if (cmdEvent) begin
            unique case (cmdByte)
                // [R12] pause field
                OP_PAUSE_OFF: begin
                    next_control1[CTRL1_PAUSE_HI:CTRL1_PAUSE_LO] = 2'h0;
                end
                OP_PAUSE_ONCE: begin
                    next_control1[CTRL1_PAUSE_HI:CTRL1_PAUSE_LO] = 2'h1;
                end
                OP_PAUSE_REPEAT: begin
                    next_control1[CTRL1_PAUSE_HI:CTRL1_PAUSE_LO] = 2'h2;
                end
                OP_PAUSE_END: begin
                    next_control1[CTRL1_PAUSE_HI:CTRL1_PAUSE_LO] = 2'h3;
                end
                // [R13] packet decrement
                OP_PACKET_COUNT_DOWN: begin
                    next_control1[CTRL1_PACKET_DECREMENT] = 1'b1;
                end
                // [R14] mover stop
                OP_MOVER_STOP: begin
                    next_control1[CTRL1_MOVER_START] = 1'b0;
                end
                // [R15] mover start
                OP_MOVER_SUM: begin
                    next_control1[CTRL1_MOVER_HI:CTRL1_MOVER_LO] = 4'h8;
                end
                OP_MOVER_SUM_SEEDED: begin
                    next_control1[CTRL1_MOVER_HI:CTRL1_MOVER_LO] = 4'hA;
                end
                OP_MOVER_COPY: begin
                    next_control1[CTRL1_MOVER_HI:CTRL1_MOVER_LO] = 4'hC;
                end
                OP_MOVER_COPY_SEEDED: begin
                    next_control1[CTRL1_MOVER_HI:CTRL1_MOVER_LO] = 4'hE;
                end
                // [R16] transmit request
                OP_SEND_PACKET: begin
                    next_control1[CTRL1_TRANSMIT_REQUEST] = 1'b1;
                end
                // [R17] receive enable
                OP_RECEIVE_ON: begin
                    next_control1[CTRL1_RECEIVE_ENABLE] = 1'b1;
                end
                OP_RECEIVE_OFF: begin
                    next_control1[CTRL1_RECEIVE_ENABLE] = 1'b0;
                end
                // unlisted 11xxxxx0 codes do nothing
                default: begin
                end
            endcase
        end
    end

    // system reset wins over every command and done pulse
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ethernetControl1 <= CTRL1_RESET;
        end else if (sysReset) begin
            ethernetControl1 <= CTRL1_RESET;
        end else begin
            ethernetControl1 <= next_control1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // system side: status word

    // [R18] irq enable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ethernetStatus <= STATUS_RESET;
        end else if (sysReset) begin
            ethernetStatus <= STATUS_RESET;
        end else if (cmdEvent && cmdByte == OP_IRQ_ON) begin
            ethernetStatus[STATUS_IRQ_ENABLE] <= 1'b1;
        end else if (cmdEvent && cmdByte == OP_IRQ_OFF) begin
            ethernetStatus[STATUS_IRQ_ENABLE] <= 1'b0;
        end
    end

endmodule // ssod_decoder

// >>> ssod_decoder_tb.sv
// self-checking bench for the short opcode decoder.
// assumes ssod_host drives the link and the checker is bound.
module ssod_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ssod_pkg::*;
    logic clk_sys, rstn, sck, csn, si, so, soOen, transmitDone, moverDone;
    logic [4:0] bankedAddr;
    logic [6:0] resolvedAddr;
    logic [1:0] bank, expB;
    logic [15:0] ethernetControl1, ethernetControl2, ethernetStatus, expC, expS;
    logic [7:0] rx;
    logic soPin;
    int errors, check_count, pulseDec, pulseRst;
    logic [7:0] ops [23] = '{OP_SELECT_BANK_THREE, OP_PAUSE_ONCE, OP_PAUSE_REPEAT,
        OP_PAUSE_END, OP_PAUSE_OFF, OP_PAUSE_REPEAT, OP_MOVER_COPY_SEEDED, OP_MOVER_COPY,
        OP_MOVER_SUM_SEEDED, OP_MOVER_SUM, OP_MOVER_STOP, OP_MOVER_COPY_SEEDED,
        OP_SEND_PACKET, OP_RECEIVE_ON, OP_RECEIVE_OFF, OP_RECEIVE_ON, OP_IRQ_ON, OP_IRQ_OFF,
        OP_IRQ_ON, OP_PACKET_COUNT_DOWN, OP_SELECT_BANK_ZERO, OP_SELECT_BANK_ONE,
        OP_SELECT_BANK_TWO};
    // released pin shows the inverse to the host, never a stale bit
    assign soPin = soOen ? ~so : so;
    ssod_host host_u (.sck, .csn, .si, .so(soPin));
    ssod_decoder dut_u (.clk_sys, .rstn, .sck, .csn, .si, .so, .soOen, .bankedAddr,
        .resolvedAddr, .transmitDone, .moverDone, .bank, .ethernetControl1,
        .ethernetControl2, .ethernetStatus);
    ////////////////////////////////////////////////////////////////
    // clock and one-cycle pulse counters
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        pulseDec += (ethernetControl1[8] === 1'b1);
        pulseRst += (ethernetControl2[4] === 1'b1);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // effects need up to 5 system cycles after the last bit
    task automatic settle();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    task automatic check_state();
        chk({14'h0000, bank}, {14'h0000, expB});
        chk(ethernetControl1, expC);
        chk(ethernetStatus, expS);
        chk({9'h000, resolvedAddr}, {9'h000, expB, bankedAddr});
    endtask
    // one opcode byte, then the expected effect worked out from its bits
    task automatic send(input logic [7:0] op);
        host_u.shift(op, 8, rx);
        settle();
        if (op[7:3] == 5'h18) expB = op[2:1];
        if (op[7:3] == 5'h1C) expC[7:6] = op[2:1];
        if (op[7:3] == 5'h1B) expC[5:2] = {1'b1, op[2:1], 1'b0};
        if (op == OP_MOVER_STOP) expC[5] = 1'b0;
        if (op == OP_SEND_PACKET) expC[1] = 1'b1;
        if (op == OP_RECEIVE_ON || op == OP_RECEIVE_OFF) expC[0] = ~op[1];
        if (op == OP_IRQ_ON || op == OP_IRQ_OFF) expS[15] = ~op[1];
        if (op == OP_SYSTEM_RESET) {expB, expC, expS} = 34'h0;
        check_state();
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog: the sequence needs well under 100 us
    initial begin
        #300000;
        errors++;
        test_done();
    end
    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        transmitDone = 1'b0;
        moverDone = 1'b0;
        bankedAddr = 5'h15;
        {expB, expC, expS} = 34'h0;
        repeat (20) @(posedge clk_sys);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 check_state();
        chk({15'h0000, soOen}, 16'h0001);
        $display("test reset done");
        host_u.open_frame();
        chk({15'h0000, soOen}, 16'h0000);
        foreach (ops[i]) send(ops[i]);
        chk(pulseDec[15:0], 16'h0001);
        send(8'hEB);
        send(8'h2A);
        host_u.shift(OP_RECEIVE_OFF, 5, rx);
        host_u.close_frame();
        settle();
        check_state();
        host_u.open_frame();
        send(OP_RECEIVE_OFF);
        host_u.close_frame();
        $display("test one-byte opcodes done");
        // the don't-care byte is a select of another bank, so running it would show
        for (int b = 0; b < 4; b++) begin
            host_u.open_frame();
            send({5'h18, b[1:0], 1'b0});
            bankedAddr = 5'(7 * b + 3);
            host_u.shift(OP_READ_BANK, 8, rx);
            host_u.shift(b[0] ? OP_SELECT_BANK_ZERO : OP_SELECT_BANK_THREE, 8, rx);
            chk({8'h00, rx}, {14'h0000, expB});
            send(b[0] ? OP_IRQ_ON : OP_IRQ_OFF);
            host_u.close_frame();
        end
        host_u.open_frame();
        host_u.shift(OP_READ_BANK, 8, rx);
        host_u.shift(OP_SELECT_BANK_ZERO, 4, rx);
        host_u.close_frame();
        settle();
        check_state();
        $display("test bank read done");
        host_u.open_frame();
        send(OP_RECEIVE_ON);
        send(OP_SYSTEM_RESET);
        chk(pulseRst[15:0], 16'h0001);
        send(OP_SELECT_BANK_ONE);
        send(OP_SEND_PACKET);
        send(OP_MOVER_COPY);
        host_u.close_frame();
        repeat (10) @(posedge clk_sys);
        #1 transmitDone = 1'b1;
        moverDone = 1'b1;
        @(posedge clk_sys);
        #1 transmitDone = 1'b0;
        moverDone = 1'b0;
        expC[1] = 1'b0;
        expC[5] = 1'b0;
        settle();
        check_state();
        $display("test system reset and done inputs done");
        rstn = 1'b0;
        settle();
        {expB, expC, expS} = 34'h0;
        check_state();
        chk(ethernetControl2, 16'h0000);
        // release again and prove the decoder runs from a clean start
        rstn = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 host_u.open_frame();
        send(OP_SELECT_BANK_ONE);
        host_u.close_frame();
        $display("test second reset done");
        test_done();
    end
endmodule // ssod_decoder_tb

// >>> ssod_host.sv
// host model: mode-0 link master driven by bench task calls.
// assumes the caller gives each byte in full unless testing a cut.
module ssod_host (
    output logic sck,
    output logic csn,
    output logic si,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////
    // idle link: clock still and low, chip select high
    initial begin
        sck = 1'b0;
        csn = 1'b1;
        si = 1'b0;
    end
    // odd offset keeps link edges off the system clock edges
    task automatic open_frame();
        #23.3 csn = 1'b0;
        #30;
    endtask
    // released data line shows the inverse, never a stale bit
    task automatic close_frame();
        #40 csn = 1'b1;
        si = ~si;
    endtask
    // msb first, mode 0, the first n bits of the byte
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si = tx[i];
            #32 sck = 1'b1;
            rx = {rx[6:0], so};
            #32 sck = 1'b0;
        end
    endtask
endmodule // ssod_host

// >>> ssod_pkg.sv
// constants for the short opcode decoder: opcodes, bit positions,
// reset values and the link phase type.
// assumes a mode-0 serial link and a 100 MHz system clock.
package ssod_pkg;

    // one-byte opcodes, pattern 11xxxxx0
    localparam logic [7:0] OP_SELECT_BANK_ZERO = 8'hC0;
    localparam logic [7:0] OP_SELECT_BANK_ONE = 8'hC2;
    localparam logic [7:0] OP_SELECT_BANK_TWO = 8'hC4;
    localparam logic [7:0] OP_SELECT_BANK_THREE = 8'hC6;
    localparam logic [7:0] OP_SYSTEM_RESET = 8'hCA;
    localparam logic [7:0] OP_PAUSE_OFF = 8'hE0;
    localparam logic [7:0] OP_PAUSE_ONCE = 8'hE2;
    localparam logic [7:0] OP_PAUSE_REPEAT = 8'hE4;
    localparam logic [7:0] OP_PAUSE_END = 8'hE6;
    localparam logic [7:0] OP_PACKET_COUNT_DOWN = 8'hCC;
    localparam logic [7:0] OP_MOVER_STOP = 8'hD2;
    localparam logic [7:0] OP_MOVER_SUM = 8'hD8;
    localparam logic [7:0] OP_MOVER_SUM_SEEDED = 8'hDA;
    localparam logic [7:0] OP_MOVER_COPY = 8'hDC;
    localparam logic [7:0] OP_MOVER_COPY_SEEDED = 8'hDE;
    localparam logic [7:0] OP_SEND_PACKET = 8'hD4;
    localparam logic [7:0] OP_RECEIVE_ON = 8'hE8;
    localparam logic [7:0] OP_RECEIVE_OFF = 8'hEA;
    localparam logic [7:0] OP_IRQ_ON = 8'hEC;
    localparam logic [7:0] OP_IRQ_OFF = 8'hEE;
    // two-byte opcode
    localparam logic [7:0] OP_READ_BANK = 8'hC8;

    // one-byte opcode frame: top two bits set, bit 0 clear
    localparam logic [1:0] SHORT_OP_TOP = 2'h3;

    // bit positions in the first ethernet control word
    localparam int CTRL1_PACKET_DECREMENT = 8;
    localparam int CTRL1_PAUSE_HI = 7;
    localparam int CTRL1_PAUSE_LO = 6;
    localparam int CTRL1_MOVER_HI = 5;
    localparam int CTRL1_MOVER_LO = 2;
    localparam int CTRL1_MOVER_START = 5;
    localparam int CTRL1_TRANSMIT_REQUEST = 1;
    localparam int CTRL1_RECEIVE_ENABLE = 0;
    // second control word and status word
    localparam int CTRL2_RESET_REQUEST = 4;
    localparam int STATUS_IRQ_ENABLE = 15;

    // reset values
    localparam logic [1:0] BANK_RESET = 2'h0;
    localparam logic [15:0] CTRL1_RESET = 16'h0000;
    localparam logic [15:0] CTRL2_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // link byte positions of the last and the first bit
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;

    // what the next link byte means
    typedef enum logic {
        PH_OPCODE,
        PH_REPLY
    } ssod_phase_t;

endpackage

// >>> ssod_sva.sv
// port checker for the short opcode decoder.
// assumes one clk_sys domain with active-low rstn; bound below.
module ssod_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic sck,
    input wire logic csn,
    input wire logic so,
    input wire logic soOen,
    input wire logic [4:0] bankedAddr,
    input wire logic [6:0] resolvedAddr,
    input wire logic transmitDone,
    input wire logic moverDone,
    input wire logic [1:0] bank,
    input wire logic [15:0] ethernetControl1,
    input wire logic [15:0] ethernetControl2,
    input wire logic [15:0] ethernetStatus
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // link pins and address path
    a_oen_tracks_cs: assert property (soOen == csn)
        else $error("so enable differs from chip select");
    a_so_on_fall: assert property (!csn && !$past(csn) && $changed(so) |-> !sck)
        else $error("so moved while sck high");
    a_addr_in_bank: assert property (resolvedAddr == {bank, bankedAddr})
        else $error("address not resolved in selected bank");
    // effects land within 5 cycles of the last bit, so a closed frame means quiet
    a_idle_no_change: assert property (csn && $past(csn) |-> $stable({bank,
        ethernetControl1[7:6], ethernetControl1[4:2], ethernetControl1[0], ethernetStatus}))
        else $error("command state moved outside a frame");
    a_decrement_pulse: assert property (ethernetControl1[8] |=> !ethernetControl1[8])
        else $error("packet decrement wider than one cycle");
    a_reset_clears: assert property (ethernetControl2[4] |=> bank == 2'h0
        && ethernetControl1 == 16'h0000 && ethernetControl2 == 16'h0000
        && ethernetStatus == 16'h0000)
        else $error("system reset left state behind");
    a_tx_done_clear: assert property (transmitDone && csn && $past(csn, 8)
        |=> !ethernetControl1[1])
        else $error("transmit request not cleared");
    a_mover_done_clear: assert property (moverDone && csn && $past(csn, 8)
        |=> !ethernetControl1[5] && $stable(ethernetControl1[4:2]))
        else $error("mover done handled wrongly");
    cover property (ethernetControl2[4]);
    cover property (bank == 2'h3 && !csn);
    cover property (ethernetControl1[5:2] == 4'hE);
    // a bank reply with a one bit on the pin
    cover property (!csn && !soOen && so);
endmodule // ssod_checker

bind ssod_decoder ssod_checker chk_u (.clk_sys, .rstn, .sck, .csn, .so, .soOen,
    .bankedAddr, .resolvedAddr, .transmitDone, .moverDone, .bank, .ethernetControl1,
    .ethernetControl2, .ethernetStatus);

// >>> ssod_sync.sv
// two-flop level synchroniser, width set by a parameter.
// assumes each bit is a level that stays put for several
// destination clock edges.
module ssod_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // ssod_sync
